// ---- hw/frsc_top.v ----
// Flash rewrite sequencer with security flags, boot swap and APB register access
// Overview of operation
// - Array is 128 blocks (256 KB) or 64 blocks (128 KB), rewritten per block
// - The whole-array erase command is always refused: its prohibit is set at reset and never cleared
// - Boot swap maps boot area 0 blocks 0-3 onto physical blocks 4-7
// - Instruction fetch path delivers four bytes every clock
// - No fetch or data access to the array during self programming; fetch is refused, but the READ command still returns array data
// - Programmer works only in programming mode, self programming in normal mode
// - Block erase clears selected block, from programmer or self programming
// - Whole-array erase only from programmer, never in self programming
// - Write programs the word then verifies the programmed level
// - Verify compares array data with supplied data, programmer only
// - Blank check reports whether array is erased, in both methods
// - Separate prohibits for block erase, chip erase, program, read, boot area
// - In self programming security may only move from permitted to prohibited
// - Shipped with block erase, chip erase and program prohibits active
// - Prohibit flags overlap: chip erase and program prohibits also refuse block erase, boot prohibit refuses chip erase
// - Interrupts keep being serviced while self programming runs
// - Completed chip erase clears block erase, program and read prohibits
// - Chip erase prohibit blocks both erases and can never be cleared
// - Program prohibit refuses program and block erase on every block
// - Boot prohibit protects blocks 0..last; chip erase keeps it
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "frsc_defs.vh"
module frsc_top #(
	parameter BLOCKS   = 128,
	parameter BLK_WORDS = 512
) (
	input  wire        pclk,       // System clock, 125 MHz
	input  wire        presetn,    // Asynchronous reset, active low
	input  wire        psel,       // APB select
	input  wire        penable,    // APB enable
	input  wire        pwrite,     // APB direction
	input  wire [11:0] paddr,      // APB byte address
	input  wire [31:0] pwdata,     // APB write data
	output reg  [31:0] prdata,     // APB read data
	output reg         pready,     // APB ready
	output reg         pslverr,    // APB error
	input  wire [17:0] fetch_addr, // Instruction fetch byte address
	output reg  [31:0] fetch_data, // Fetched word
	output reg         fetch_err,  // Fetch refused during self programming
	output reg         busy        // Sequencer busy
);
	// Word address is block number above the word-in-block index
	localparam NBLK = (BLOCKS == 128) ? 7 : 6;
	localparam BW   = $clog2(BLK_WORDS);
	localparam WA   = NBLK + BW;
	localparam AW   = WA + 2;

	localparam S_IDLE   = 3'h0;
	localparam S_ERASE  = 3'h1;
	localparam S_PROG   = 3'h2;
	localparam S_VERIFY = 3'h3;
	localparam S_BLANK  = 3'h4;
	localparam S_CMP    = 3'h5;
	localparam S_WAIT   = 3'h6;

	reg  [2:0]    ctrl_reg;
	reg  [2:0]    state_reg;
	reg  [2:0]    cmd_reg;
	reg  [WA-1:0] addr_reg;
	reg  [31:0]   wdata_reg;
	reg  [4:0]    sec_reg;
	reg  [6:0]    last_reg;
	reg  [4:0]    status_reg;
	reg  [31:0]   result_reg;
	reg  [WA-1:0] ptr_reg;
	reg  [WA-1:0] end_reg;
	reg           chip_reg;

	wire        acc      = psel & penable & ~pready;
	wire        wr       = acc & pwrite;
	wire        selfprog = ctrl_reg[`FRSC_CTRL_SELFPROG];
	wire        pgmode   = ctrl_reg[`FRSC_CTRL_PGMODE];
	wire [WA-1:0] blk_word = addr_reg >> BW;
	wire [6:0]    cmd_blk  = blk_word[6:0];

	// Boot swap: blocks 0-3 and 4-7 trade places
	function [WA-1:0] swap_map;
		input [WA-1:0] a;
		input          en;
		begin
			swap_map = a;
			if (en && (a[WA-1 : BW] < 8)) begin
				swap_map[BW+2] = ~a[BW+2];
			end
		end
	endfunction

	// Refusal checks; block erase also looks at the chip erase and program prohibits
	reg refuse;
	always @* begin
		refuse = 1'b0;
		case (cmd_reg)
		`FRSC_CMD_BLKERASE: begin
			refuse = sec_reg[`FRSC_SEC_BLKERASE] | sec_reg[`FRSC_SEC_CHIPERASE]
				| sec_reg[`FRSC_SEC_PROGRAM];
			if (sec_reg[`FRSC_SEC_BOOT] && cmd_blk <= last_reg) begin
				refuse = 1'b1;
			end
		end
		`FRSC_CMD_CHIPERASE: begin
			refuse = sec_reg[`FRSC_SEC_CHIPERASE] | sec_reg[`FRSC_SEC_BOOT]
				| selfprog;
		end
		`FRSC_CMD_WRITE: begin
			refuse = sec_reg[`FRSC_SEC_PROGRAM];
			if (sec_reg[`FRSC_SEC_BOOT] && cmd_blk <= last_reg) begin
				refuse = 1'b1;
			end
		end
		`FRSC_CMD_VERIFY: refuse = selfprog | sec_reg[`FRSC_SEC_READ];
		`FRSC_CMD_READ:   refuse = sec_reg[`FRSC_SEC_READ];
		`FRSC_CMD_BLANK:  refuse = 1'b0;
		default:          refuse = 1'b1;
		endcase
		if (pgmode == selfprog) begin
			refuse = 1'b1;
		end
	end

	wire          arr_we   = (state_reg == S_ERASE) || (state_reg == S_PROG);
	wire [WA-1:0] arr_wa   = (state_reg == S_PROG) ? addr_reg : ptr_reg;
	wire [31:0]   arr_wd   = (state_reg == S_PROG) ? wdata_reg : `FRSC_ERASED_WORD;
	// Read and verify fetch their word while the command is still being decided
	wire [WA-1:0] arr_ra   = (state_reg == S_IDLE || state_reg == S_WAIT) ? addr_reg : ptr_reg;
	wire [31:0]   rd_a;
	wire [31:0]   rd_b;
	wire [WA-1:0] fetch_wa = swap_map(fetch_addr[AW-1:2], ctrl_reg[`FRSC_CTRL_SWAP]);

	frsc_array #(
		.AW(WA)
	) u_array (
		.pclk    (pclk),
		.we      (arr_we),
		.waddr   (arr_wa),
		.wdata   (arr_wd),
		.raddr_a (arr_ra),
		.rdata_a (rd_a),
		.raddr_b (fetch_wa),
		.rdata_b (rd_b)
	);

	// Sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= S_IDLE;
			ptr_reg    <= {WA{1'b0}};
			end_reg    <= {WA{1'b0}};
			status_reg <= 5'h00;
			result_reg <= 32'h00000000;
			chip_reg   <= 1'b0;
		end else begin
			case (state_reg)
			S_IDLE: begin
				if (wr && paddr == `FRSC_OFF_CMD) begin
					status_reg[`FRSC_ST_DONE] <= 1'b0;
					status_reg[`FRSC_ST_ERR]  <= 1'b0;
					state_reg <= S_WAIT;
				end
			end
			S_WAIT: begin
				status_reg[`FRSC_ST_MISMATCH] <= 1'b0;
				if (refuse) begin
					status_reg[`FRSC_ST_ERR]  <= 1'b1;
					status_reg[`FRSC_ST_DONE] <= 1'b1;
					state_reg <= S_IDLE;
				end else begin
					case (cmd_reg)
					`FRSC_CMD_BLKERASE: begin
						ptr_reg   <= {cmd_blk[NBLK-1:0], {BW{1'b0}}};
						end_reg   <= {cmd_blk[NBLK-1:0], {BW{1'b1}}};
						chip_reg  <= 1'b0;
						state_reg <= S_ERASE;
					end
					`FRSC_CMD_CHIPERASE: begin
						ptr_reg   <= {WA{1'b0}};
						end_reg   <= {WA{1'b1}};
						chip_reg  <= 1'b1;
						state_reg <= S_ERASE;
					end
					`FRSC_CMD_WRITE: state_reg <= S_PROG;
					`FRSC_CMD_BLANK: begin
						ptr_reg   <= {WA{1'b0}};
						status_reg[`FRSC_ST_BLANK] <= 1'b1;
						state_reg <= S_BLANK;
					end
					default: state_reg <= S_CMP; // Read and verify
					endcase
				end
			end
			S_ERASE: begin
				ptr_reg <= ptr_reg + 1'b1;
				if (ptr_reg == end_reg) begin
					status_reg[`FRSC_ST_DONE] <= 1'b1;
					state_reg <= S_IDLE;
				end
			end
			S_PROG: begin
				ptr_reg   <= addr_reg;
				state_reg <= S_VERIFY;
			end
			S_VERIFY: state_reg <= S_CMP;
			S_BLANK: begin
				// Read data trails the pointer by one cycle; last word is checked in S_CMP
				if (ptr_reg != {WA{1'b0}} && rd_a != `FRSC_ERASED_WORD) begin
					status_reg[`FRSC_ST_BLANK] <= 1'b0;
				end
				ptr_reg <= ptr_reg + 1'b1;
				if (ptr_reg == {WA{1'b1}}) begin
					state_reg <= S_CMP;
				end
			end
			S_CMP: begin
				result_reg <= rd_a;
				if (cmd_reg == `FRSC_CMD_BLANK && rd_a != `FRSC_ERASED_WORD) begin
					status_reg[`FRSC_ST_BLANK] <= 1'b0;
				end
				if ((cmd_reg == `FRSC_CMD_WRITE || cmd_reg == `FRSC_CMD_VERIFY)
					&& rd_a != wdata_reg) begin
					status_reg[`FRSC_ST_MISMATCH] <= 1'b1;
					status_reg[`FRSC_ST_ERR]      <= (cmd_reg == `FRSC_CMD_WRITE);
				end
				status_reg[`FRSC_ST_DONE] <= 1'b1;
				state_reg <= S_IDLE;
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end

	wire erase_done = (state_reg == S_ERASE) && (ptr_reg == end_reg) && chip_reg;

	// Registers written over APB
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg  <= 3'h0;
			cmd_reg   <= `FRSC_CMD_NONE;
			addr_reg  <= {WA{1'b0}};
			wdata_reg <= 32'h00000000;
			sec_reg   <= `FRSC_SEC_RESET;
			last_reg  <= `FRSC_LAST_RESET;
		end else begin
			if (erase_done) begin
				sec_reg[`FRSC_SEC_BLKERASE] <= 1'b0;
				sec_reg[`FRSC_SEC_PROGRAM]  <= 1'b0;
				sec_reg[`FRSC_SEC_READ]     <= 1'b0;
			end
			if (wr && state_reg == S_IDLE) begin
				case (paddr)
				`FRSC_OFF_CTRL:  ctrl_reg  <= pwdata[2:0];
				`FRSC_OFF_CMD:   cmd_reg   <= pwdata[2:0];
				`FRSC_OFF_ADDR:  addr_reg  <= pwdata[AW-1:2];
				`FRSC_OFF_WDATA: wdata_reg <= pwdata;
				`FRSC_OFF_SECURITY: begin
					if (pgmode && !selfprog) begin
						// Chip erase prohibit never returns to permitted
						sec_reg <= pwdata[4:0] | (sec_reg & 5'h02);
						last_reg <= pwdata[`FRSC_SEC_LAST_LSB +: 7];
					end else if (selfprog) begin
						sec_reg <= sec_reg | pwdata[4:0];
						if (!sec_reg[`FRSC_SEC_BOOT] && pwdata[`FRSC_SEC_BOOT]) begin
							last_reg <= pwdata[`FRSC_SEC_LAST_LSB +: 7];
						end
					end
				end
				default: ;
				endcase
			end
		end
	end

	// Read mux and APB answer; one wait state gives every access three cycles, setup included
	reg [31:0] rd_mux;
	always @* begin
		case (paddr)
		`FRSC_OFF_CTRL:     rd_mux = {29'h0, ctrl_reg};
		`FRSC_OFF_CMD:      rd_mux = {29'h0, cmd_reg};
		`FRSC_OFF_ADDR:     rd_mux = {{(32-AW){1'b0}}, addr_reg, 2'h0};
		`FRSC_OFF_WDATA:    rd_mux = wdata_reg;
		`FRSC_OFF_STATUS:   rd_mux = {27'h0, status_reg[4:1], state_reg != S_IDLE};
		`FRSC_OFF_SECURITY: rd_mux = {17'h0, last_reg, 3'h0, sec_reg};
		`FRSC_OFF_RESULT:   rd_mux = result_reg;
		`FRSC_OFF_FETCH:    rd_mux = {14'h0, fetch_addr};
		default:            rd_mux = 32'h00000000;
		endcase
	end

	wire unmapped = (paddr[1:0] != 2'h0) || (paddr > `FRSC_OFF_FETCH);
	wire busy_wr  = pwrite && state_reg != S_IDLE && paddr != `FRSC_OFF_STATUS;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata     <= 32'h00000000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			fetch_data <= 32'h00000000;
			fetch_err  <= 1'b0;
			busy       <= 1'b0;
		end else begin
			pready  <= acc;
			pslverr <= acc & (unmapped | busy_wr);
			prdata  <= (acc && !pwrite) ? rd_mux : 32'h00000000;
			// Interrupt logic is outside and never held off by the sequencer
			busy    <= (state_reg != S_IDLE);
			fetch_err <= selfprog;
			fetch_data <= selfprog ? 32'h00000000 : rd_b;
		end
	end
endmodule

// ---- hw/frsc_defs.vh ----
// Register map, field positions and reset values of the flash rewrite controller
`ifndef FRSC_DEFS_VH
`define FRSC_DEFS_VH
`define FRSC_OFF_CTRL      12'h000
`define FRSC_OFF_CMD       12'h004
`define FRSC_OFF_ADDR      12'h008
`define FRSC_OFF_WDATA     12'h00C
`define FRSC_OFF_STATUS    12'h010
`define FRSC_OFF_SECURITY  12'h014
`define FRSC_OFF_RESULT    12'h018
`define FRSC_OFF_FETCH     12'h01C
// Control register fields
`define FRSC_CTRL_PGMODE   0
`define FRSC_CTRL_SELFPROG 1
`define FRSC_CTRL_SWAP     2
// Command codes
`define FRSC_CMD_NONE      3'h0
`define FRSC_CMD_BLKERASE  3'h1
`define FRSC_CMD_CHIPERASE 3'h2
`define FRSC_CMD_WRITE     3'h3
`define FRSC_CMD_VERIFY    3'h4
`define FRSC_CMD_BLANK     3'h5
`define FRSC_CMD_READ      3'h6
// Security register fields
`define FRSC_SEC_BLKERASE  0
`define FRSC_SEC_CHIPERASE 1
`define FRSC_SEC_PROGRAM   2
`define FRSC_SEC_READ      3
`define FRSC_SEC_BOOT      4
`define FRSC_SEC_LAST_LSB  8
// Shipped security state: block erase, chip erase and program prohibited
`define FRSC_SEC_RESET     5'h07
`define FRSC_LAST_RESET    7'h03
// Status fields
`define FRSC_ST_BUSY       0
`define FRSC_ST_DONE       1
`define FRSC_ST_ERR        2
`define FRSC_ST_MISMATCH   3
`define FRSC_ST_BLANK      4
// Erased word value; the erase loop writes it one word per cycle
`define FRSC_ERASED_WORD   32'hFFFFFFFF
`endif

// ---- hw/frsc_array.v ----
// Flash word array with one write port and two read ports
`timescale 1ns/10ps
module frsc_array #(
	parameter AW = 12
) (
	input  wire          pclk,     // System clock
	input  wire          we,       // Write enable
	input  wire [AW-1:0] waddr,    // Write word address
	input  wire [31:0]   wdata,    // Write data
	input  wire [AW-1:0] raddr_a,  // Sequencer read address
	output reg  [31:0]   rdata_a,  // Sequencer read data
	input  wire [AW-1:0] raddr_b,  // Fetch read address
	output reg  [31:0]   rdata_b   // Fetch read data, one word per cycle
);
	reg [31:0] mem [0:(1<<AW)-1];

	always @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_a <= mem[raddr_a];
		rdata_b <= mem[raddr_b];
	end
endmodule

// ---- sim/frsc_top_sva.sv ----
// Port-level checks of the flash rewrite controller
`timescale 1ns/10ps
module frsc_chk (
	input wire        pclk,       // Clock
	input wire        presetn,    // Reset, active low
	input wire        psel,       // APB select
	input wire        penable,    // APB enable
	input wire [11:0] paddr,      // APB address
	input wire [31:0] prdata,     // APB read data
	input wire        pready,     // APB ready
	input wire        pslverr,    // APB error
	input wire [31:0] fetch_data, // Fetched word
	input wire        fetch_err,  // Fetch refused
	input wire        busy        // Sequencer busy
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Outputs stay unknown until the first edge has applied reset
	reg edge_seen = 1'b0;
	always @(posedge pclk) edge_seen <= 1'b1;
	sequence acc_start;
		psel && penable && !pready && !$past(penable);
	endsequence
	sequence one_answer;
		pready ##1 !pready;
	endsequence
	AST_ANSWER: assert property (acc_start |=> one_answer)
		else $error("answer is not a one-cycle pready");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_RD_ZERO: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside the answer");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	AST_UNMAPPED: assert property (acc_start and paddr > 12'h01C |=> pready && pslverr)
		else $error("unmapped offset not refused");
	AST_UNALIGNED: assert property (acc_start and paddr[1:0] != 2'h0 |=> pslverr)
		else $error("unaligned offset not refused");
	AST_FETCH_BLOCK: assert property (fetch_err && $past(fetch_err) && $past(fetch_err, 2)
		|-> fetch_data == 32'h0)
		else $error("flash word delivered during self programming");
	AST_RESET: assert property (disable iff (1'b0) !presetn && edge_seen
		|-> !pready && !pslverr && !fetch_err && !busy)
		else $error("outputs active during reset");
endmodule
bind frsc_top frsc_chk frsc_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .fetch_data(fetch_data), .fetch_err(fetch_err), .busy(busy));

// ---- sim/frsc_host.sv ----
// APB master standing in for the programmer or the self-programming software
`timescale 1ns/10ps
module frsc_host (
	input  wire        pclk,            // Clock
	input  wire        pready,          // APB ready
	input  wire        pslverr,         // APB error
	input  wire [31:0] prdata,          // APB read data
	output reg         psel    = 1'b0,  // APB select
	output reg         penable = 1'b0,  // APB enable
	output reg         pwrite  = 1'b0,  // APB direction
	output reg  [11:0] paddr   = 12'h0, // APB address
	output reg  [31:0] pwdata  = 32'h0  // APB write data
);
	// Register traffic only: never touches the array while self programming
	task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r, output e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ---- sim/tb_frsc_top.sv ----
// Self-checking bench of the flash rewrite controller
`timescale 1ns/10ps
module tb_frsc_top;
	reg         pclk       = 1'b0;
	reg         presetn    = 1'b0;
	reg  [17:0] fetch_addr = 18'h0;
	wire        psel, penable, pwrite, pready, pslverr, fetch_err, busy;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata, fetch_data;
	integer     n_mismatch  = 0;
	integer     check_count = 0;
	integer     cyc         = 0;
	reg  [31:0] r, sec, d, a;
	reg         e;
	always #4 pclk = ~pclk;
	frsc_top frsc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
		.fetch_err(fetch_err), .busy(busy));
	frsc_host frsc_host_i (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	task cmp(input [31:0] got, input [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input [11:0] ad, input [31:0] dt);
		frsc_host_i.xfer(1'b1, ad, dt, r, e);
	endtask
	task rd(input [11:0] ad);
		frsc_host_i.xfer(1'b0, ad, 32'h0, r, e);
	endtask
	// Writes the command, polls for done, leaves the status word in r
	task op(input [2:0] c, input [31:0] ad, input [31:0] dt, input bit err);
		integer k;
		wr(12'h008, ad);
		wr(12'h00C, dt);
		wr(12'h004, {29'h0, c});
		@(negedge pclk);
		cmp({31'h0, busy}, 32'h1);
		k = 0;
		do begin
			rd(12'h010);
			k = k + 1;
		end while (r[1] !== 1'b1 && k < 200);
		cmp(r & 32'h6, err ? 32'h6 : 32'h2);
	endtask
	// Chip erase prohibit can never drop; software may only add prohibits
	function [31:0] sec_next(input [31:0] old, input [31:0] nw, input bit sp);
		sec_next = (sp ? (old | nw) : (nw | (old & 32'h2))) & 32'h7F1F;
	endfunction
	task setsec(input [31:0] v, input bit sp);
		wr(12'h014, v);
		sec = sec_next(sec, v, sp);
		rd(12'h014);
		cmp(r, sec);
	endtask
	task fetch(input [17:0] fa);
		fetch_addr <= fa;
		repeat (3) @(posedge pclk);
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch = n_mismatch + 1;
			final_report;
		end
	end
	initial begin
		d = $urandom(32'hDF21D10F);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		sec = 32'h0307;
		rd(12'h014);
		cmp(r, sec);
		rd(12'h020);
		cmp({31'h0, e}, 32'h1);
		rd(12'h006);
		cmp({31'h0, e}, 32'h1);
		wr(12'h000, 32'h1);
		a = 32'h10000 | ($urandom & 32'hFFFC);
		d = $urandom;
		op(3'h3, a, d, 1'b1);
		op(3'h1, a, d, 1'b1);
		op(3'h2, a, d, 1'b1);
		setsec(32'h0, 1'b0);
		$display("test shipped security done");
		op(3'h3, a, d, 1'b0);
		op(3'h6, a, d, 1'b0);
		rd(12'h018);
		cmp(r, d);
		op(3'h4, a, d, 1'b0);
		cmp(r & 32'h8, 32'h0);
		op(3'h4, a, ~d, 1'b0);
		cmp(r & 32'h8, 32'h8);
		op(3'h1, a, d, 1'b1);
		fetch(a[17:0]);
		cmp(fetch_data, d);
		rd(12'h01C);
		cmp(r, {14'h0, a[17:0]});
		op(3'h3, 32'h2000, ~d, 1'b0);
		wr(12'h000, 32'h5);
		fetch(18'h0);
		cmp(fetch_data, ~d);
		$display("test program and swap done");
		wr(12'h000, 32'h1);
		setsec(32'h0310, 1'b0);
		op(3'h3, 32'h1000, d, 1'b1);
		op(3'h2, a, d, 1'b1);
		wr(12'h000, 32'h3);
		op(3'h6, a, d, 1'b1);
		op(3'h5, a, d, 1'b1);
		wr(12'h000, 32'h2);
		op(3'h4, a, d, 1'b1);
		op(3'h2, a, d, 1'b1);
		op(3'h3, a + 32'h4, d, 1'b0);
		setsec(32'h0, 1'b1);
		setsec(32'h8, 1'b1);
		op(3'h6, a, d, 1'b1);
		fetch(a[17:0]);
		cmp({31'h0, fetch_err}, 32'h1);
		cmp(fetch_data, 32'h0);
		$display("test self programming done");
		final_report;
	end
endmodule
